/* core/suspend_pin_ctrl.sv */
// Suspend indicator and pin function selection for two serial ports.
// Assumes USB events arrive as one-cycle pulses on core_clk and the
// one-time configuration is stable ports.
// Functional notes
// - Enter suspended state when bus suspend signalling is detected once configured.
// - On suspend assert sleep output only on interfaces in user mode.
// - After reset keep sleep asserted until enumeration configures device.
// - Sleep polarity is active-low unless configuration selects high.
// - Leave suspend on resume seen or sent, bus reset, or reset.
// - Deassert sleep output on resume; after a bus reset it stays asserted until configured.
// - Sleep output driver disabled during device reset; weak pull up.
// - While suspended apply configured level and drive type to output-enabled pins.
// - Clear-to-send inputs are active-low; low permits transmission.
// - Request-to-send outputs are driven active-low.
// - Enhanced modem mode: terminal-ready out, set-ready and carrier in low.
// - Enhanced modem mode: ring-indicator input on sleep pin, active-low.
// - User mode: terminal/set-ready pins become configurable user pins.
// - User mode: carrier-detect pin has no function.
// - Both interfaces default to user pin mode out of reset.
module suspend_pin_ctrl
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                usb_suspend_det,
  input  wire logic                usb_resume_det,
  input  wire logic                usb_resume_gen,
  input  wire logic                usb_bus_reset,
  input  wire logic                usb_configured,
  input  wire logic                cfg_valid,
  input  wire logic                cfg_enh_modem,
  input  wire logic                cfg_std_modem,
  input  wire logic                cfg_sleep_active_high,
  input  wire logic [1:0]          cfg_susp_level,
  input  wire logic [1:0]          cfg_susp_od,
  input  wire logic [1:0]          user_out,
  input  wire logic [1:0]          user_oe,
  input  wire logic [1:0]          user_od,
  output logic      [1:0]          user_in,
  input  wire logic                enh_rts_req,
  input  wire logic                std_rts_req,
  input  wire logic                enh_dtr_req,
  input  wire logic                enh_clear_to_send_n,
  input  wire logic                std_clear_to_send_n,
  output logic                     enh_cts_ok,
  output logic                     std_cts_ok,
  output logic                     enh_request_to_send_n,
  output logic                     std_request_to_send_n,
  input  wire logic                enh_pin0_in,
  output logic                     enh_pin0_out,
  output logic                     enh_pin0_oe,
  input  wire logic                enh_pin1_in,
  output logic                     enh_pin1_out,
  output logic                     enh_pin1_oe,
  input  wire logic                enh_carrier_detect_n,
  output logic                     enh_dsr_active,
  output logic                     enh_dcd_active,
  input  wire logic                enh_sleep_pin_in,
  output logic                     enh_sleep_out,
  output logic                     enh_sleep_oe,
  output logic                     std_sleep_out,
  output logic                     std_sleep_oe,
  output logic                     enh_ri_active,
  output logic                     suspended
);
  // ----------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------
  // One-time settings are latched once valid; later changes ignored.
  logic       cfg_done_q, cfg_done_d;
  logic [1:0] mode_q, mode_d;
  logic       pol_q, pol_d;
  always_comb
  begin
    cfg_done_d = cfg_done_q;
    mode_d     = mode_q;
    pol_d      = pol_q;
    if (cfg_valid && !cfg_done_q)
    begin
      cfg_done_d = 1'b1;
      mode_d[suspend_pin_pkg::IF_ENH] = cfg_enh_modem;
      mode_d[suspend_pin_pkg::IF_STD] = cfg_std_modem;
      pol_d      = cfg_sleep_active_high;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_done_q <= 1'b0;
      mode_q     <= {suspend_pin_pkg::NUM_IF{suspend_pin_pkg::MODE_RESET}};
      pol_q      <= suspend_pin_pkg::POL_RESET;
    end
    else
    begin
      cfg_done_q <= cfg_done_d;
      mode_q     <= mode_d;
      pol_q      <= pol_d;
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  suspend_pin_pkg::power_state_t st_q, st_d;
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      suspend_pin_pkg::ST_UNCONFIGURED:
        if (usb_configured)
          st_d = suspend_pin_pkg::ST_ACTIVE;
      suspend_pin_pkg::ST_ACTIVE:
        if (usb_suspend_det)
          st_d = suspend_pin_pkg::ST_SUSPENDED;
      suspend_pin_pkg::ST_SUSPENDED:
        // Bus reset drops back to unconfigured so re-enumeration holds sleep
        if (usb_bus_reset)
          st_d = suspend_pin_pkg::ST_UNCONFIGURED;
        else if (usb_resume_det || usb_resume_gen)
          st_d = suspend_pin_pkg::ST_ACTIVE;
      default:
        st_d = suspend_pin_pkg::ST_UNCONFIGURED;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= suspend_pin_pkg::ST_UNCONFIGURED;
    else
      st_q <= st_d;
  end

  logic susp_now;
  logic sleep_assert;
  assign susp_now     = (st_q == suspend_pin_pkg::ST_SUSPENDED);
  assign sleep_assert = (st_q != suspend_pin_pkg::ST_ACTIVE);
  assign suspended    = susp_now;

  // ----------------------------------------------------------------
  // Sleep indicator outputs (registered)
  // ----------------------------------------------------------------
  logic [1:0] sleep_val_q, sleep_val_d;
  logic [1:0] sleep_oe_q, sleep_oe_d;
  always_comb
  begin
    for (int i = 0; i < suspend_pin_pkg::NUM_IF; i++)
    begin
      // Only user-mode interfaces own the pin for the indicator.
      // Next mode and polarity are used so a modem-mode ring input is
      // never driven for a cycle right after the settings are captured.
      sleep_oe_d[i]  = (mode_d[i] == suspend_pin_pkg::MODE_GPIO);
      sleep_val_d[i] = sleep_assert ~^ pol_d;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_oe_q  <= '0;
      sleep_val_q <= '1;
    end
    else
    begin
      sleep_oe_q  <= sleep_oe_d;
      sleep_val_q <= sleep_val_d;
    end
  end
  // Pad keeps its weak pull-up while the enable is low
  assign enh_sleep_out = sleep_val_q[suspend_pin_pkg::IF_ENH];
  assign enh_sleep_oe  = sleep_oe_q[suspend_pin_pkg::IF_ENH];
  assign std_sleep_out = sleep_val_q[suspend_pin_pkg::IF_STD];
  assign std_sleep_oe  = sleep_oe_q[suspend_pin_pkg::IF_STD];

  // ----------------------------------------------------------------
  // Handshake and modem inputs (active low)
  // ----------------------------------------------------------------
  logic enh_modem;
  assign enh_modem  = (mode_q[suspend_pin_pkg::IF_ENH] == suspend_pin_pkg::MODE_MODEM);
  assign enh_cts_ok = !enh_clear_to_send_n;
  assign std_cts_ok = !std_clear_to_send_n;
  assign enh_dsr_active = enh_modem && !enh_pin1_in;
  assign enh_dcd_active = enh_modem && !enh_carrier_detect_n;
  assign enh_ri_active  = enh_modem && !enh_sleep_pin_in;

  // RTS registered so the pin is glitch free
  logic [1:0] rts_n_q, rts_n_d;
  always_comb
  begin
    rts_n_d = {!std_rts_req, !enh_rts_req};
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rts_n_q <= '1;
    else
      rts_n_q <= rts_n_d;
  end
  assign enh_request_to_send_n = rts_n_q[0];
  assign std_request_to_send_n = rts_n_q[1];

  // ----------------------------------------------------------------
  // Shared user pins
  // ----------------------------------------------------------------
  pin_drive_if pin0_if ();
  pin_drive_if pin1_if ();

  // Pin0 is terminal-ready (output, active low) in modem mode
  pin_mux u_pin0
  (
    .mode_modem (enh_modem),
    .modem_out  (!enh_dtr_req),
    .modem_oe   (1'b1),
    .user_out   (user_out[0]),
    .user_oe    (user_oe[0]),
    .user_od    (user_od[0]),
    .susp_apply (susp_now),
    .susp_level (cfg_susp_level[0]),
    .susp_od    (cfg_susp_od[0]),
    .pin_in     (enh_pin0_in),
    .pin        (pin0_if)
  );
  // Pin1 is set-ready input in modem mode, so never driven there
  pin_mux u_pin1
  (
    .mode_modem (enh_modem),
    .modem_out  (1'b1),
    .modem_oe   (1'b0),
    .user_out   (user_out[1]),
    .user_oe    (user_oe[1]),
    .user_od    (user_od[1]),
    .susp_apply (susp_now),
    .susp_level (cfg_susp_level[1]),
    .susp_od    (cfg_susp_od[1]),
    .pin_in     (enh_pin1_in),
    .pin        (pin1_if)
  );
  assign enh_pin0_out = pin0_if.out_val;
  assign enh_pin0_oe  = pin0_if.out_en;
  assign enh_pin1_out = pin1_if.out_val;
  assign enh_pin1_oe  = pin1_if.out_en;
  // User inputs read zero in modem mode
  assign user_in = enh_modem ? 2'h0 : {pin1_if.in_val, pin0_if.in_val};
endmodule

/* core/suspend_pin_pkg.sv */
// Package for the suspend indicator and pin function block.
// Assumes a single 40 MHz core clock and active-low asynchronous reset.
package suspend_pin_pkg;
  // ----------------------------------------------------------------
  // Pin modes
  // ----------------------------------------------------------------
  localparam logic MODE_GPIO  = 1'b0;
  localparam logic MODE_MODEM = 1'b1;
  localparam logic MODE_RESET = MODE_GPIO;
  // Sleep polarity: 0 active-low (default), 1 active-high
  localparam logic POL_RESET  = 1'b0;
  localparam int   NUM_IF     = 2;
  localparam int   IF_ENH     = 0;
  localparam int   IF_STD     = 1;
  localparam int   NUM_USER   = 2;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_UNCONFIGURED,
    ST_ACTIVE,
    ST_SUSPENDED
  } power_state_t;
endpackage

/* core/pin_drive_if.sv */
// Interface carrying one pin's drive and read values between modules.
// Assumes the top module resolves these onto the real pin ports.
interface pin_drive_if;
  logic out_val;
  logic out_en;
  logic open_drain;
  logic in_val;
  // The mux owns all four, including the read value it passes through
  modport src (output out_val, output out_en, output open_drain,
               output in_val);
  modport dst (input out_val, input out_en, input open_drain,
               input in_val);
endinterface

/* core/pin_mux.sv */
// Per-pin function multiplexer: modem function or user function,
// with suspend override. Assumes inputs synchronous to core_clk.
module pin_mux
(
  input  wire logic    mode_modem,
  input  wire logic    modem_out,
  input  wire logic    modem_oe,
  input  wire logic    user_out,
  input  wire logic    user_oe,
  input  wire logic    user_od,
  input  wire logic    susp_apply,
  input  wire logic    susp_level,
  input  wire logic    susp_od,
  input  wire logic    pin_in,
  pin_drive_if.src     pin
);
  // ----------------------------------------------------------------
  // Mux
  // ----------------------------------------------------------------
  logic val;
  logic oe;
  logic od;
  always_comb
  begin
    if (mode_modem)
    begin
      val = modem_out;
      oe  = modem_oe;
      od  = 1'b0;
    end
    else
    begin
      val = user_out;
      oe  = user_oe;
      od  = user_od;
    end
    if (susp_apply && oe)
    begin
      val = susp_level;
      od  = susp_od;
    end
    // Open drain only drives low; high comes from the pull-up
    if (od && val)
      oe = 1'b0;
  end
  assign pin.out_val    = val;
  assign pin.out_en     = oe;
  assign pin.open_drain = od;
  assign pin.in_val     = pin_in;
endmodule

/* dv/suspend_pin_sva.sv */
// Checker for the suspend indicator and pin function block.
// Assumes it sees only the top ports, all in the core_clk domain.
module suspend_pin_sva
(
  input wire logic       core_clk, rst_n, usb_suspend_det,
  input wire logic       usb_resume_det, usb_resume_gen, usb_bus_reset,
  input wire logic       cfg_sleep_active_high,
  input wire logic [1:0] cfg_susp_level,
  input wire logic       enh_dtr_req, enh_pin0_out, enh_pin0_oe,
  input wire logic       enh_sleep_out, enh_sleep_oe, enh_ri_active,
  input wire logic       suspended
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  susp_enter_a: assert property
    ($rose(suspended) |-> $past(usb_suspend_det))
    else $error("suspend without cause");
  susp_exit_a: assert property
    (suspended && (usb_resume_det || usb_resume_gen || usb_bus_reset)
     |=> !suspended) else $error("suspend not left");
  sleep_on_a: assert property
    ($rose(suspended) && enh_sleep_oe
     |=> enh_sleep_out == cfg_sleep_active_high)
    else $error("sleep not asserted");
  sleep_off_a: assert property
    ($fell(suspended) && enh_sleep_oe && !$past(usb_bus_reset)
     |=> enh_sleep_out == !cfg_sleep_active_high)
    else $error("sleep not released");
  // Reset gating is lifted here: this one speaks of the reset itself
  sleep_hiz_a: assert property
    (disable iff (1'b0) !rst_n |-> !enh_sleep_oe)
    else $error("sleep driven in reset");
  ring_gate_a: assert property
    (enh_ri_active |-> !enh_sleep_oe) else $error("ring in user mode");
  dtr_drive_a: assert property
    (enh_ri_active && !suspended |->
     enh_pin0_oe && enh_pin0_out == !enh_dtr_req)
    else $error("terminal ready wrong");
  susp_level_a: assert property
    (suspended && enh_pin0_oe |-> enh_pin0_out == cfg_susp_level[0])
    else $error("suspend level wrong");
  cover property ($rose(suspended));
  cover property ($fell(suspended) && $past(usb_bus_reset));
  cover property (enh_ri_active && enh_pin0_oe);
endmodule

bind suspend_pin_ctrl suspend_pin_sva u_sva
(
  .core_clk(core_clk), .rst_n(rst_n), .usb_suspend_det(usb_suspend_det),
  .usb_resume_det(usb_resume_det), .usb_resume_gen(usb_resume_gen),
  .usb_bus_reset(usb_bus_reset), .cfg_susp_level(cfg_susp_level),
  .cfg_sleep_active_high(cfg_sleep_active_high), .suspended(suspended),
  .enh_dtr_req(enh_dtr_req), .enh_pin0_out(enh_pin0_out),
  .enh_pin0_oe(enh_pin0_oe), .enh_sleep_out(enh_sleep_out),
  .enh_sleep_oe(enh_sleep_oe), .enh_ri_active(enh_ri_active)
);

/* dv/serial_far_model.sv */
// Far-side serial circuitry: pull-ups, modem lines and handshake.
// Assumes the bench sets its drive controls just after clock edges.
module serial_far_model
(
  input  wire logic       pin0_out, pin0_oe, pin1_out, pin1_oe,
  input  wire logic       sleep_out, sleep_oe, ext1_en, ext1_val, ring_n,
  input  wire logic [1:0] permit,
  output logic            pin0_in, pin1_in, sleep_in, enh_cts_n, std_cts_n
);
  // Released pin0 reads the pull-up, pin1 ext1_val or the pull-up, sleep pin ring_n; never a stale level
  assign pin0_in = pin0_oe ? pin0_out : 1'b1;
  assign pin1_in = pin1_oe ? pin1_out : (ext1_en ? ext1_val : 1'b1);
  assign sleep_in = sleep_oe ? sleep_out : ring_n;
  assign enh_cts_n = !permit[0];
  assign std_cts_n = !permit[1];
endmodule

/* dv/suspend_pin_ctrl_test.sv */
// Self-checking bench for the suspend indicator and pin function block.
// Assumes the far-side model resolves the shared enhanced pins.
module suspend_pin_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, rst_n, cv, em, sm, ah, dtr, dcd_n, x_en, x_val;
  logic       ring_n, p0o, p0e, p1o, p1e, dsr, dcd, slo, sle, sso, sse;
  logic       ri, susp, p0i, p1i, sli, ecn, scn;
  logic [4:0] evt;
  logic [1:0] lvl, od, uo, uoe, uod, rts, permit, uin, ok, rts_n;
  int         err_count, samples_checked;

  suspend_pin_ctrl u_dut
  (
    .core_clk(core_clk), .rst_n(rst_n), .usb_suspend_det(evt[0]),
    .usb_resume_det(evt[1]), .usb_resume_gen(evt[2]),
    .usb_bus_reset(evt[3]), .usb_configured(evt[4]), .cfg_valid(cv),
    .cfg_enh_modem(em), .cfg_std_modem(sm), .cfg_sleep_active_high(ah),
    .cfg_susp_level(lvl), .cfg_susp_od(od), .user_out(uo), .user_oe(uoe),
    .user_od(uod), .user_in(uin), .enh_rts_req(rts[0]),
    .std_rts_req(rts[1]), .enh_dtr_req(dtr), .enh_clear_to_send_n(ecn),
    .std_clear_to_send_n(scn), .enh_cts_ok(ok[0]), .std_cts_ok(ok[1]),
    .enh_request_to_send_n(rts_n[0]), .std_request_to_send_n(rts_n[1]),
    .enh_pin0_in(p0i), .enh_pin0_out(p0o), .enh_pin0_oe(p0e),
    .enh_pin1_in(p1i), .enh_pin1_out(p1o), .enh_pin1_oe(p1e),
    .enh_carrier_detect_n(dcd_n), .enh_dsr_active(dsr),
    .enh_dcd_active(dcd), .enh_sleep_pin_in(sli), .enh_sleep_out(slo),
    .enh_sleep_oe(sle), .std_sleep_out(sso), .std_sleep_oe(sse),
    .enh_ri_active(ri), .suspended(susp)
  );
  serial_far_model u_far
  (
    .pin0_out(p0o), .pin0_oe(p0e), .pin1_out(p1o), .pin1_oe(p1e),
    .sleep_out(slo), .sleep_oe(sle), .ext1_en(x_en), .ext1_val(x_val),
    .ring_n(ring_n), .permit(permit), .pin0_in(p0i), .pin1_in(p1i),
    .sleep_in(sli), .enh_cts_n(ecn), .std_cts_n(scn)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // -------
  // Helpers
  // -------
  task automatic chk(input string n, input logic [3:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    evt <= 5'h01 << k;
    @(posedge core_clk);
    evt <= 5'h00;
    @(negedge core_clk);
  endtask
  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One-time setting c is {valid, enh modem, std modem, high polarity}
  task automatic rst_cfg(input logic [3:0] c);
    @(posedge core_clk);
    rst_n <= 1'b0;
    {cv, em, sm, ah} <= c;
    step(10);
    chk("sleep_oe", 4'h0, {sle, sse});
    chk("sleep_pin", 4'h1, sli);
    chk("rts_n", 4'h3, rts_n);
    @(posedge core_clk);
    rst_n <= 1'b1;
    step(1);
  endtask
  task automatic t_suspend();
    rst_cfg(4'h8);
    pulse(4);
    step(1);
    chk("sleep_out", 4'h3, {slo, sso});
    for (int k = 1; k < 4; k++)
    begin
      // Second pass suspends open-drain: the high level must float
      @(posedge core_clk);
      od <= (k == 2) ? 2'h3 : 2'h0;
      pulse(0);
      chk("susp", 4'h1, susp);
      chk("pins", 4'h2, {p1o, p0o});
      chk("pins_oe", (k == 2) ? 4'h1 : 4'h3, {p1e, p0e});
      step(1);
      chk("sleep_out", 4'h0, {slo, sso});
      pulse(k);
      chk("susp", 4'h0, susp);
      step(1);
      chk("sleep_out", (k == 3) ? 4'h0 : 4'h3, {slo, sso});
      chk("pins", 4'h1, {p1o, p0o});
      chk("pins_oe", 4'h3, {p1e, p0e});
      if (k == 3)
      begin
        // Unconfigured after bus reset, so a suspend is not taken
        pulse(0);
        chk("susp", 4'h0, susp);
      end
    end
  endtask
  task automatic t_handshake();
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge core_clk);
      rts <= 2'(i);
      permit <= 2'(i);
      step(1);
      chk("rts_n", {2'h0, ~2'(i)}, rts_n);
      chk("cts_ok", 4'(i), ok);
    end
  endtask
  task automatic t_modem();
    @(posedge core_clk);
    {dtr, x_en, x_val, dcd_n} <= 4'hC;
    rst_cfg(4'hD);
    @(posedge core_clk);
    ring_n <= 1'b0;
    step(1);
    chk("sleep_oe", 4'h1, {sle, sse});
    chk("std_sleep", 4'h1, sso);
    chk("dtr_pin", 4'h2, {p0e, p0o});
    chk("pin1_oe", 4'h0, p1e);
    chk("modem_in", 4'h7, {dsr, dcd, ri});
    chk("user_in", 4'h0, uin);
    @(posedge core_clk);
    {dtr, x_val, dcd_n, ring_n} <= 4'h7;
    step(1);
    chk("dtr_pin", 4'h3, {p0e, p0o});
    chk("modem_in", 4'h0, {dsr, dcd, ri});
  endtask
  // Standard port in modem mode gives up its sleep pin from the first edge
  task automatic t_std_modem();
    rst_cfg(4'hA);
    chk("sleep_oe", 4'h2, {sle, sse});
    chk("enh_sleep", 4'h0, slo);
  endtask

  initial
  begin
    rst_n = 1'b0;
    {cv, em, sm, ah, dtr, dcd_n, x_en, x_val, ring_n} = 9'h001;
    evt = 5'h00;
    // Suspend level 10, push-pull, user drives pin0 high and pin1 low
    {lvl, od, uo, uoe, uod, rts, permit} = 14'h21C0;
    err_count = 0;
    samples_checked = 0;
    rst_cfg(4'h0);
    step(3);
    chk("sleep_oe", 4'h3, {sle, sse});
    chk("sleep_out", 4'h0, {slo, sso});
    chk("pin0", 4'h3, {p0e, p0o});
    chk("user_in", 4'h1, uin);
    chk("dcd", 4'h0, dcd);
    t_suspend();
    t_handshake();
    t_modem();
    t_std_modem();
    finish_test();
  end
  initial
  begin
    repeat (4000) @(posedge core_clk);
    $display("ERROR watchdog expected done seen hang");
    err_count++;
    finish_test();
  end
endmodule
